// ==== atam_alert_monitor.sv ====
// Behaviour
// - CRC-rejected write sets sticky bit 9
// - Setup load error sets bit 8
// - Only hard reset or power-up reset clears load error
// - Channel B over high sets bit 5
// - Channel B under low sets flag
// - Channel A over high sets bit 1
// - Channel A under low sets bit 0
// - Low compare value is field, then 0x0
// - High compare value is field, then 0xF
// - Low alert when result below low value
// - High alert when result above high value
// - Word bits 15:12 carry register address
// - Alarm pin only in one-wire with enable
// - Soft reset code clears alert status
// - Hard reset code restores all defaults
`timescale 1ns/100ps
`default_nettype none

module atam_alert_monitor
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Register access from the serial framing logic
   input wire atam_pkg::atam_access_s acc,
   output logic [15:0] rd_data,
   // Events from the serial and setup logic
   input wire logic crc_reject,
   input wire logic setup_load_fail,
   input wire logic alert_enable,
   // Conversion results
   input wire atam_pkg::atam_sample_s sample,
   // Setup outputs
   output logic output_wire_select,
   output logic soft_reset_pulse,
   output logic hard_reset_pulse,
   // Shared second output pin, alarm function
   output logic alarm_active,
   output logic alarm_drive
);

   // ==========================================================
   // Helpers shared by both channels and all register decodes
   // A strobe aimed at one register address
   function automatic logic atam_hit(input logic strobe,
      input logic [3:0] addr, input logic [3:0] target);
      return strobe && addr == target;
   endfunction : atam_hit

   // Internal 16-bit limit: twelve-bit field over a fixed fill nibble
   function automatic logic [15:0] atam_limit(input logic [11:0] field,
      input logic [3:0] fill);
      return {field, fill};
   endfunction : atam_limit

   // Strict compares; a result equal to a limit raises nothing
   function automatic logic atam_below(input logic [15:0] x,
      input logic [15:0] lim);
      return x < lim;
   endfunction : atam_below

   function automatic logic atam_above(input logic [15:0] x,
      input logic [15:0] lim);
      return x > lim;
   endfunction : atam_above

   // Sticky flag: a new event beats a clear landing in the same cycle,
   // so an alert raised during a status read is never lost
   function automatic logic atam_sticky(input logic hit, input logic cur,
      input logic clr);
      return hit | (cur & ~clr);
   endfunction : atam_sticky

   // ==========================================================
   // Decode
   logic [3:0] acc_addr;
   logic wr_setup2, wr_low, wr_high, rd_status;
   logic soft_hit, hard_hit;
   logic [11:0] low_field;
   logic [11:0] high_field;
   logic [15:0] status;
   logic [15:0] low_cmp, high_cmp;
   logic a_under, a_over, b_under, b_over;

   assign acc_addr = acc.data[atam_pkg::ADDR_MSB:atam_pkg::ADDR_LSB];
   assign wr_setup2 = atam_hit(acc.wr, acc_addr, atam_pkg::ADDR_SETUP2);
   assign wr_low = atam_hit(acc.wr, acc_addr, atam_pkg::ADDR_LOW);
   assign wr_high = atam_hit(acc.wr, acc_addr, atam_pkg::ADDR_HIGH);
   assign rd_status = atam_hit(acc.rd, acc_addr, atam_pkg::ADDR_STATUS);
   // Other reset field codes are simply ignored
   assign soft_hit = wr_setup2 &&
      acc.data[atam_pkg::RST_MSB:0] == atam_pkg::SOFT_RESET_CODE;
   assign hard_hit = wr_setup2 &&
      acc.data[atam_pkg::RST_MSB:0] == atam_pkg::HARD_RESET_CODE;

   // ==========================================================
   // Comparison values: field in the upper twelve bits
   assign low_cmp = atam_limit(low_field, atam_pkg::LOW_FILL);
   assign high_cmp = atam_limit(high_field, atam_pkg::HIGH_FILL);

   // Equality is neither below nor above, so no alert is raised on it
   assign a_under = sample.valid &&
      atam_below(sample.chan_a, low_cmp);
   assign b_under = sample.valid &&
      atam_below(sample.chan_b, low_cmp);
   assign a_over = sample.valid &&
      atam_above(sample.chan_a, high_cmp);
   assign b_over = sample.valid &&
      atam_above(sample.chan_b, high_cmp);

   // ==========================================================
   // Threshold registers, hard reset returns defaults
   always_ff @(posedge sys_clk)
   begin
      if (srst || hard_hit)
      begin
         low_field <= atam_pkg::LOW_RESET;
         high_field <= atam_pkg::HIGH_RESET;
      end
      else
      begin
         if (wr_low)
            low_field <= acc.data[atam_pkg::THR_MSB:0];
         if (wr_high)
            high_field <= acc.data[atam_pkg::THR_MSB:0];
      end
   end

   // Output wire select; the enable bit itself lives in first setup word
   always_ff @(posedge sys_clk)
   begin
      if (srst || hard_hit)
         output_wire_select <= 1'b0;
      else if (wr_setup2)
         output_wire_select <= acc.data[atam_pkg::OWS_BIT];
   end

   // ==========================================================
   // Sticky flags, read-clear except load error; a new event beats the clear
   logic crcw_flag, a_under_flag, a_over_flag;
   logic b_under_flag, b_over_flag, load_err_flag;
   logic flag_clr;

   // Status read, soft reset and hard reset all clear the channel flags
   assign flag_clr = rd_status | soft_hit | hard_hit;

   // Flags follow their events on every edge, power-up reset wins
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         crcw_flag <= 1'b0;
         a_under_flag <= 1'b0;
         a_over_flag <= 1'b0;
         b_under_flag <= 1'b0;
         b_over_flag <= 1'b0;
      end
      else
      begin
         crcw_flag <= atam_sticky(crc_reject, crcw_flag, flag_clr);
         a_under_flag <= atam_sticky(a_under, a_under_flag, flag_clr);
         a_over_flag <= atam_sticky(a_over, a_over_flag, flag_clr);
         b_under_flag <= atam_sticky(b_under, b_under_flag, flag_clr);
         b_over_flag <= atam_sticky(b_over, b_over_flag, flag_clr);
      end
   end

   // Load error survives reads and soft reset; hard reset reruns setup,
   // but a failure reported in that same cycle still sticks
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         load_err_flag <= 1'b0;
      else
         load_err_flag <= atam_sticky(setup_load_fail, load_err_flag,
            hard_hit);
   end

   // ==========================================================
   // Status word and read data, address echoed in top nibble
   always_comb
   begin
      status = 16'h0000;
      status[atam_pkg::ADDR_MSB:atam_pkg::ADDR_LSB] = atam_pkg::ADDR_STATUS;
      status[atam_pkg::CRCW_BIT] = crcw_flag;
      status[atam_pkg::LOADERR_BIT] = load_err_flag;
      status[atam_pkg::B_OVER_BIT] = b_over_flag;
      status[atam_pkg::B_UNDER_BIT] = b_under_flag;
      status[atam_pkg::A_OVER_BIT] = a_over_flag;
      status[atam_pkg::A_UNDER_BIT] = a_under_flag;
   end

   // Read data registered; captured before the read clears the flags
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         rd_data <= 16'h0000;
      else if (acc.rd)
      begin
         unique case (acc_addr)
            atam_pkg::ADDR_STATUS: rd_data <= status;
            atam_pkg::ADDR_LOW: rd_data <= {atam_pkg::ADDR_LOW, low_field};
            atam_pkg::ADDR_HIGH: rd_data <= {atam_pkg::ADDR_HIGH, high_field};
            default: rd_data <= {acc_addr, 12'h000};
         endcase
      end
   end

   // ==========================================================
   // Reset pulses to the rest of the device
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         soft_reset_pulse <= 1'b0;
         hard_reset_pulse <= 1'b0;
      end
      else
      begin
         soft_reset_pulse <= soft_hit;
         hard_reset_pulse <= hard_hit;
      end
   end

   // Alarm pin; in two-wire mode the pin carries data and enable is ignored
   assign alarm_active = a_under_flag | a_over_flag |
      b_under_flag | b_over_flag;
   assign alarm_drive = output_wire_select & alert_enable;

endmodule : atam_alert_monitor

`default_nettype wire

// ==== atam_pkg.sv ====
package atam_pkg;

   // ==========================================================
   // Register addresses (carried in word bits 15:12)
   localparam logic [3:0] ADDR_SETUP2 = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_LOW = 4'h4;
   localparam logic [3:0] ADDR_HIGH = 4'h5;

   // ==========================================================
   // Word layout
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int THR_MSB = 11;
   localparam int RST_MSB = 7;
   localparam int OWS_BIT = 8;
   localparam int ALERT_EN_BIT = 3;

   // ==========================================================
   // Status bit positions
   localparam int CRCW_BIT = 9;
   localparam int LOADERR_BIT = 8;
   localparam int B_OVER_BIT = 5;
   localparam int B_UNDER_BIT = 4;
   localparam int A_OVER_BIT = 1;
   localparam int A_UNDER_BIT = 0;

   // ==========================================================
   // Reset values and codes
   localparam logic [11:0] LOW_RESET = 12'h800;
   localparam logic [11:0] HIGH_RESET = 12'h7FF;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h3C;
   localparam logic [7:0] HARD_RESET_CODE = 8'hFF;
   localparam logic [3:0] LOW_FILL = 4'h0;
   localparam logic [3:0] HIGH_FILL = 4'hF;

   // ==========================================================
   // Register access carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] data;
   } atam_access_s;

   // One conversion pair
   typedef struct packed {
      logic valid;
      logic [15:0] chan_a;
      logic [15:0] chan_b;
   } atam_sample_s;

endpackage : atam_pkg

// ==== atam_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checker for the alert monitor
module atam_chk
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Watched ports
   input wire atam_pkg::atam_access_s acc,
   input wire logic [15:0] rd_data,
   input wire logic crc_reject,
   input wire logic setup_load_fail,
   input wire logic alert_enable,
   input wire atam_pkg::atam_sample_s sample,
   input wire logic output_wire_select,
   input wire logic soft_reset_pulse,
   input wire logic hard_reset_pulse,
   input wire logic alarm_active,
   input wire logic alarm_drive
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Decoded views of the access word
   wire logic [3:0] ad = acc.data[15:12];
   wire logic st_rd = acc.rd && ad == atam_pkg::ADDR_STATUS;
   wire logic cfg_wr = acc.wr && ad == atam_pkg::ADDR_SETUP2;
   wire logic quiet = !crc_reject && !sample.valid;
   // Read, idle, read with no event that could set a flag
   sequence two_reads;
      st_rd && quiet ##1 quiet ##1 st_rd && quiet;
   endsequence
   a_crc_sticky: assert property (
      crc_reject ##1 st_rd |=> rd_data[9])
      else $error("write crc flag missing from status read");
   a_load_seen: assert property (
      setup_load_fail ##1 st_rd |=> rd_data[8])
      else $error("load error flag missing from status read");
   a_read_clears: assert property (
      two_reads |=> !(|(rd_data & 16'h0233)))
      else $error("sticky flags survived a status read");
   a_addr_echo: assert property (
      acc.rd |=> rd_data[15:12] == $past(ad))
      else $error("read word lacks its address");
   a_alarm_gate: assert property (
      alarm_drive == (output_wire_select && alert_enable))
      else $error("alarm pin use does not follow mode and enable");
   a_ows_write: assert property (
      cfg_wr && acc.data[7:0] == 8'h00 |=>
      output_wire_select == $past(acc.data[8]))
      else $error("one-wire select not taken from setup write");
   a_soft_code: assert property (
      cfg_wr && acc.data[7:0] == 8'h3C |=> soft_reset_pulse)
      else $error("soft reset code gave no pulse");
   a_hard_code: assert property (
      cfg_wr && acc.data[7:0] == 8'hFF |=> hard_reset_pulse)
      else $error("hard reset code gave no pulse");
   a_alarm_clear: assert property (
      st_rd && !sample.valid |=> !alarm_active)
      else $error("alarm stayed up after a status read");
endmodule : atam_chk
bind atam_alert_monitor atam_chk u_atam_chk (
   .sys_clk(sys_clk),
   .srst(srst),
   .acc(acc),
   .rd_data(rd_data),
   .crc_reject(crc_reject),
   .setup_load_fail(setup_load_fail),
   .alert_enable(alert_enable),
   .sample(sample),
   .output_wire_select(output_wire_select),
   .soft_reset_pulse(soft_reset_pulse),
   .hard_reset_pulse(hard_reset_pulse),
   .alarm_active(alarm_active),
   .alarm_drive(alarm_drive)
);
`default_nettype wire

// ==== atam_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host model: one register word per transfer
module atam_host
(
   // Clock
   input wire logic sys_clk,
   // Register access toward the monitor
   output var atam_pkg::atam_access_s acc
);
   // Idle at time zero
   initial acc = '0;
   // Held over one rising edge; released data is inverted so a stale word
   // can never pass for a live one
   task automatic io(input logic w, input logic [15:0] d);
      @(negedge sys_clk) acc <= '{w, !w, d};
      @(negedge sys_clk) acc <= '{1'b0, 1'b0, ~d};
   endtask : io
endmodule : atam_host
`default_nettype wire

// ==== atam_alert_monitor_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[ERR] %0t %h %h", $time, g, e); end end
// ==========================================
// Alert monitor bench
module atam_alert_monitor_tb;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic crc_reject = 1'b0;
   logic setup_load_fail = 1'b0;
   logic alert_enable = 1'b0;
   atam_pkg::atam_sample_s sample = '0;
   atam_pkg::atam_access_s acc;
   logic [15:0] rd_data, a, b;
   logic output_wire_select, alarm_active, alarm_drive;
   logic [11:0] lo = 12'h800;
   logic [11:0] hi = 12'h7FF;
   logic [16:0] lf = 17'h11A97;
   int n_mismatch = 0;
   int samples_checked = 0;
   // Design and host
   atam_alert_monitor u_atam_alert_monitor (
      .sys_clk(sys_clk),
      .srst(srst),
      .acc(acc),
      .rd_data(rd_data),
      .crc_reject(crc_reject),
      .setup_load_fail(setup_load_fail),
      .alert_enable(alert_enable),
      .sample(sample),
      .output_wire_select(output_wire_select),
      .soft_reset_pulse(),
      .hard_reset_pulse(),
      .alarm_active(alarm_active),
      .alarm_drive(alarm_drive)
   );
   atam_host u_atam_host (
      .sys_clk(sys_clk),
      .acc(acc)
   );
   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;
   // Stepper, x^17 + x^14 + 1
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   // Strict compares: a result equal to a limit raises nothing
   function automatic logic [15:0] ex(input logic [15:0] x, y);
      return {4'h3, 10'h000, x > {hi, 4'hF}, x < {lo, 4'h0}} |
         {10'h000, y > {hi, 4'hF}, y < {lo, 4'h0}, 4'h0};
   endfunction : ex
   // Read one register and compare
   task automatic rd(input logic [3:0] ad, input logic [15:0] e);
      u_atam_host.io(1'b0, {ad, 12'h000});
      `CK(rd_data, e)
   endtask : rd
   // One conversion pair
   task automatic smp(input logic [15:0] x, y);
      @(negedge sys_clk) sample <= '{1'b1, x, y};
      @(negedge sys_clk) sample.valid <= 1'b0;
   endtask : smp
   // Count summary and verdict
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial
   begin
      repeat (20) @(negedge sys_clk);
      srst = 1'b0;
      rd(4'h3, 16'h3000);
      rd(4'h4, 16'h4800);
      rd(4'h5, 16'h57FF);
      $display("reset test done");
      repeat (30)
      begin
         lf = lfsr(lf);
         lo = lf[11:0];
         lf = lfsr(lf);
         hi = lf[11:0];
         u_atam_host.io(1'b1, {4'h4, lo});
         u_atam_host.io(1'b1, {4'h5, hi});
         lf = lfsr(lf);
         a = lf[16] ? {lo, 4'h0} - {15'h0, lf[0]} : lf[15:0];
         lf = lfsr(lf);
         b = lf[16] ? {hi, 4'hF} + {15'h0, lf[0]} : lf[15:0];
         smp(a, b);
         rd(4'h3, ex(a, b));
         rd(4'h5, {4'h5, hi});
      end
      $display("limit test done");
      // Flag set in the same cycle as a read wins over the clear
      crc_reject = 1'b1;
      setup_load_fail = 1'b1;
      rd(4'h3, 16'h3300);
      crc_reject = 1'b0;
      setup_load_fail = 1'b0;
      rd(4'h3, 16'h3300);
      rd(4'h3, 16'h3100);
      smp(16'h0000, 16'hFFFF);
      u_atam_host.io(1'b1, 16'h203C);
      rd(4'h3, 16'h3100);
      rd(4'h4, {4'h4, lo});
      u_atam_host.io(1'b1, 16'h20FF);
      repeat (2) @(negedge sys_clk);
      rd(4'h3, 16'h3000);
      rd(4'h4, 16'h4800);
      lo = 12'h800;
      hi = 12'h7FF;
      $display("status test done");
      // Enable alone in two-wire mode must leave the pin carrying data
      alert_enable = 1'b1;
      #2 `CK(alarm_drive, 1'b0)
      u_atam_host.io(1'b1, 16'h2100);
      `CK(output_wire_select, 1'b1)
      smp(16'h0000, 16'h0000);
      `CK({alarm_drive, alarm_active}, 2'b11)
      rd(4'h3, ex(16'h0000, 16'h0000));
      `CK(alarm_active, 1'b0)
      alert_enable = 1'b0;
      #2 `CK(alarm_drive, 1'b0)
      $display("alarm test done");
      print_verdict();
   end
   // Watchdog, far past the few hundred cycles the tests need
   initial
   begin
      #100000;
      n_mismatch++;
      print_verdict();
   end
endmodule : atam_alert_monitor_tb
`default_nettype wire
